// file: hw/trigger_or_mask.sv
// Trigger OR masks, card trigger sequence and multi-purpose connector outputs.
//
// Functional notes
// - Legacy write one: first connector run state, second trigger out.
// - Legacy write zero: both connectors disabled.
// - Last written of legacy/mode wins.
// - Standard output asserts after trigger delay.
// - User delay postpones standard output, recording.
// - Direct output asserts at recognised event.
// - Direct: user delay only postpones recording.
// - Separate general and channel masks.
// - Source counts only when enabled.
// - One bit per source in masks.
// - Availability register shows existing general sources.
// - Mask codes: none, software, analog.
// - Mask codes: first and second TTL.
// - Software source triggers right after start.
// - Analog source triggers when condition valid.
// - General mask resets to software only.
// - Channel mask: one bit per channel.
// - Mode changes apply on start/write-setup.
// - Trigger out high during post count.
// - Run state high while acquisition runs.
module trigger_or_mask
  import trig_or_pkg::*;
#(
  parameter int NCH = 4,
  parameter logic [3:0] GEN_AVAIL = 4'hf,
  parameter logic [31:0] FIXED_DELAY = 32'h0000_0004
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  input wire logic analogCond,
  input wire logic [NCH-1:0] chanCond,
  input wire logic firstConnIn,
  output logic firstConnOut,
  output logic firstConnOeN,
  input wire logic secondConnIn,
  output logic secondConnOut,
  output logic secondConnOeN,
  output logic cardTrig,
  output logic running
);

  // ----------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------
  if (NCH < 1 || NCH > 32) begin : g_bad_nch
    $error("NCH must lie between 1 and 32.");
  end
  // The reset mask enables the software source, so that source must
  // exist; otherwise the mask would hold a bit that reads as absent.
  if (GEN_AVAIL[BIT_SW] != 1'b1) begin : g_bad_avail
    $error("GEN_AVAIL must include the software source.");
  end

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  // Modes come in pairs: the staged copy is what software last wrote,
  // the active copy drives the connectors. A mode write reads back at
  // once, while the pins only follow at the next start or write-setup,
  // so a running acquisition sees a connector change only at such a command.
  logic [3:0] genMask, next_genMask;
  logic [NCH-1:0] chMask, next_chMask;
  logic [31:0] legacyReg, next_legacyReg;
  logic [31:0] modeFirst, next_modeFirst;
  logic [31:0] modeSecond, next_modeSecond;
  logic [31:0] actFirst, next_actFirst;
  logic [31:0] actSecond, next_actSecond;
  logic [31:0] trigDelay, next_trigDelay;
  logic [31:0] postCount, next_postCount;
  logic [1:0] outStyle, next_outStyle;
  logic [31:0] next_rdData;
  logic wrCmd, startCmd, stopCmd, setupCmd;

  // Command strokes are pulses decoded straight from the write.
  // Several command bits may come in one write; stop then wins over
  // start in the sequence logic.
  assign wrCmd = wrStb && (addr == ADDR_COMMAND);
  assign startCmd = wrCmd && wrData[CMD_START];
  assign stopCmd = wrCmd && wrData[CMD_STOP];
  assign setupCmd = wrCmd && wrData[CMD_WRITE_SETUP];

  // ----------------------------------------------------------------
  // Sequence state.
  // ----------------------------------------------------------------
  // Idle waits for start, armed waits for an enabled source, delay
  // counts the fixed latency plus the user delay, post counts the post
  // area. One counter serves both timed states, as they never overlap.
  // A start while the card is busy is ignored, so a run cannot be
  // restarted halfway; software stops it first.
  card_state_e state, next_state;
  logic [31:0] cnt, next_cnt;
  logic directOut, next_directOut;
  logic trigEvent;
  logic [3:0] genSrc;
  logic [NCH-1:0] chanPad;

  // Each general source sits on its own mask bit; TTL inputs only count when
  // their connector is really set up as trigger input.
  // The software source is a constant one: an enabled software bit
  // fires at the first armed cycle and hides every other source.
  always_comb begin
    genSrc = 4'h0;
    genSrc[BIT_SW] = 1'b1;
    genSrc[BIT_ANALOG] = analogCond;
    genSrc[BIT_TTL0] = firstConnIn && (actFirst == connector_trigger_input_mode);
    genSrc[BIT_TTL1] = secondConnIn && (actSecond == connector_trigger_input_mode);
  end

  // Channel conditions pass unchanged; the separate name leaves room
  // for a per-channel qualifier without touching the OR below.
  assign chanPad = chanCond;
  // One OR over both masked groups forms the card trigger.
  assign trigEvent = |(genSrc & genMask) || |(chanPad & chMask);

  // ----------------------------------------------------------------
  // Register file next values.
  // ----------------------------------------------------------------
  // Every register holds its value unless its address is written; the active modes change on start or write-setup. The
  // legacy register keeps a single bit and also rewrites both staged
  // modes, which is how the later of the two methods wins. Mode writes
  // are taken whole, so an unknown code simply leaves the pin released;
  // mixing both methods in one program is best avoided.
  always_comb begin
    next_genMask = genMask;
    next_chMask = chMask;
    next_legacyReg = legacyReg;
    next_modeFirst = modeFirst;
    next_modeSecond = modeSecond;
    next_actFirst = actFirst;
    next_actSecond = actSecond;
    next_trigDelay = trigDelay;
    next_postCount = postCount;
    next_outStyle = outStyle;
    if (wrStb) begin
      case (addr)
        ADDR_GEN_MASK: next_genMask = wrData[3:0] & GEN_AVAIL;
        ADDR_CH_MASK: next_chMask = wrData[NCH-1:0];
        ADDR_LEGACY_OUT: begin
          next_legacyReg = {31'h0000_0000, wrData[0]};
          // Rewrites the staged modes, so the later of the two methods wins.
          if (wrData[0]) begin
            next_modeSecond = connector_trigger_output_mode;
            next_modeFirst = connector_run_state_mode;
          end else begin
            next_modeSecond = connector_disabled_mode;
            next_modeFirst = connector_disabled_mode;
          end
        end
        ADDR_MODE_FIRST: next_modeFirst = wrData;
        ADDR_MODE_SECOND: next_modeSecond = wrData;
        ADDR_TRIG_DELAY: next_trigDelay = wrData;
        ADDR_POST_COUNT: next_postCount = wrData;
        ADDR_OUT_STYLE: next_outStyle = wrData[1:0];
        default: ;
      endcase
    end
    // Staged modes reach the pins only on start or write-setup.
    if (startCmd || setupCmd) begin
      next_actFirst = next_modeFirst;
      next_actSecond = next_modeSecond;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  // Zero outside a read keeps the bus quiet, so read data of several
  // blocks may be ORed together.
  always_comb begin
    next_rdData = 32'h0000_0000;
    if (rdStb) begin
      case (addr)
        ADDR_GEN_MASK: next_rdData = {28'h000_0000, genMask};
        ADDR_AVAIL_GEN: next_rdData = {28'h000_0000, GEN_AVAIL};
        ADDR_CH_MASK: next_rdData[NCH-1:0] = chMask;
        ADDR_AVAIL_CH: next_rdData[NCH-1:0] = '1;
        ADDR_LEGACY_OUT: next_rdData = legacyReg;
        ADDR_MODE_FIRST: next_rdData = modeFirst;
        ADDR_MODE_SECOND: next_rdData = modeSecond;
        ADDR_TRIG_DELAY: next_rdData = trigDelay;
        ADDR_POST_COUNT: next_rdData = postCount;
        ADDR_OUT_STYLE: next_rdData = {30'h0000_0000, outStyle};
        ADDR_STATUS: begin
          next_rdData[STAT_RUN] = (state != ST_IDLE);
          next_rdData[STAT_TRIG] = cardTrig;
          next_rdData[STAT_ARMED] = (state == ST_ARMED);
        end
        default: next_rdData = 32'h0000_0000;
      endcase
    end
  end

  // Register file flops.
  // Reset brings the general mask back with the software source on, so
  // a start straight after reset triggers at once.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      genMask <= GEN_MASK_RESET;
      chMask <= '0;
      legacyReg <= 32'h0000_0000;
      modeFirst <= connector_disabled_mode;
      modeSecond <= connector_disabled_mode;
      actFirst <= connector_disabled_mode;
      actSecond <= connector_disabled_mode;
      trigDelay <= TRIG_DELAY_RESET;
      postCount <= POST_COUNT_RESET;
      outStyle <= 2'h0;
      rdData <= 32'h0000_0000;
    end else begin
      genMask <= next_genMask;
      chMask <= next_chMask;
      legacyReg <= next_legacyReg;
      modeFirst <= next_modeFirst;
      modeSecond <= next_modeSecond;
      actFirst <= next_actFirst;
      actSecond <= next_actSecond;
      trigDelay <= next_trigDelay;
      postCount <= next_postCount;
      outStyle <= next_outStyle;
      rdData <= next_rdData;
    end
  end

  // ----------------------------------------------------------------
  // Card sequence: armed, trigger delay, post-trigger count.
  // ----------------------------------------------------------------
  // The delay holds the fixed latency plus the user delay; it is counted in
  // both styles, only the output timing differs. Counts of zero or one
  // both give one cycle, so neither the delay nor the post area is
  // skipped. In FIFO style the post area has no end of its own: only stop
  // leaves it. A huge user delay wraps the sum; that is left to software.
  // The counter runs on the one clock, so all figures are in cycles.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_directOut = directOut;
    case (state)
      ST_IDLE: begin
        next_directOut = 1'b0;
        if (startCmd) begin
          next_state = ST_ARMED;
        end
      end
      // Direct style raises its flag here, at the recognised event.
      ST_ARMED: begin
        if (trigEvent) begin
          next_directOut = outStyle[STYLE_DIRECT];
          next_cnt = FIXED_DELAY + trigDelay;
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cnt <= 32'h0000_0001) begin
          next_cnt = postCount;
          next_state = ST_POST;
        end else begin
          next_cnt = cnt - 32'h0000_0001;
        end
      end
      // Outside FIFO style the post area ends when the count runs out.
      ST_POST: begin
        if (!outStyle[STYLE_FIFO]) begin
          if (cnt <= 32'h0000_0001) begin
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt - 32'h0000_0001;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Stop is applied last so that it wins over every other move.
    if (stopCmd) begin
      next_state = ST_IDLE;
      next_directOut = 1'b0;
    end
    // Leaving for idle always clears the direct flag as well.
    if (next_state == ST_IDLE) begin
      next_directOut = 1'b0;
    end
  end

  // Sequence flops.
  // The counter is cleared on reset only for tidiness; every path that
  // reads it has loaded it first.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 32'h0000_0000;
      directOut <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      directOut <= next_directOut;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs, all registered.
  // ----------------------------------------------------------------
  // Pin values are worked out from the next state and registered, so
  // each pin changes on the same edge as the state, free of glitches.
  logic next_cardTrig, next_running;
  logic next_firstOut, next_firstOeN, next_secondOut, next_secondOeN;

  // Standard style rises at the post area; direct style already at the event.
  // Direct style leads by the whole delay, which lets outside equipment
  // start before recording does.
  assign next_cardTrig = (next_state == ST_POST) || next_directOut;
  assign next_running = (next_state != ST_IDLE);

  // Output enable is low while a connector drives; other modes release it.
  // A released pin keeps its outgoing level low, so a later switch to
  // output starts from low.
  always_comb begin
    next_firstOut = 1'b0;
    next_firstOeN = 1'b1;
    next_secondOut = 1'b0;
    next_secondOeN = 1'b1;
    case (next_actFirst)
      connector_trigger_output_mode: begin
        next_firstOut = next_cardTrig;
        next_firstOeN = 1'b0;
      end
      connector_run_state_mode: begin
        next_firstOut = next_running;
        next_firstOeN = 1'b0;
      end
      default: ;
    endcase
    case (next_actSecond)
      connector_trigger_output_mode: begin
        next_secondOut = next_cardTrig;
        next_secondOeN = 1'b0;
      end
      connector_run_state_mode: begin
        next_secondOut = next_running;
        next_secondOeN = 1'b0;
      end
      default: ;
    endcase
  end

  // Output flops.
  // Reset releases both connectors; nothing is driven until software
  // picks a mode and applies it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cardTrig <= 1'b0;
      running <= 1'b0;
      firstConnOut <= 1'b0;
      firstConnOeN <= 1'b1;
      secondConnOut <= 1'b0;
      secondConnOeN <= 1'b1;
    end else begin
      cardTrig <= next_cardTrig;
      running <= next_running;
      firstConnOut <= next_firstOut;
      firstConnOeN <= next_firstOeN;
      secondConnOut <= next_secondOut;
      secondConnOeN <= next_secondOeN;
    end
  end

endmodule : trigger_or_mask

// file: hw/trig_or_pkg.sv
// Constants shared by the trigger source selection and trigger output block.
package trig_or_pkg;

  // ----------------------------------------------------------------
  // Register offsets, taken as word addresses on the plain port.
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_LEGACY_OUT = 16'h9ca4;
  localparam logic [15:0] ADDR_AVAIL_GEN = 16'h9dd0;
  localparam logic [15:0] ADDR_GEN_MASK = 16'h9dda;
  localparam logic [15:0] ADDR_AVAIL_CH = 16'h9e02;
  localparam logic [15:0] ADDR_CH_MASK = 16'h9e0c;
  localparam logic [15:0] ADDR_MODE_FIRST = 16'ha000;
  localparam logic [15:0] ADDR_MODE_SECOND = 16'ha004;
  localparam logic [15:0] ADDR_COMMAND = 16'ha010;
  localparam logic [15:0] ADDR_TRIG_DELAY = 16'ha020;
  localparam logic [15:0] ADDR_POST_COUNT = 16'ha024;
  localparam logic [15:0] ADDR_OUT_STYLE = 16'ha028;
  localparam logic [15:0] ADDR_STATUS = 16'ha030;

  // ----------------------------------------------------------------
  // General mask bits and reset values.
  // ----------------------------------------------------------------
  localparam int GEN_W = 4;
  localparam logic [3:0] no_source_selected = 4'h0;
  localparam logic [3:0] software_source_enable = 4'h1;
  localparam logic [3:0] analog_external_source_enable = 4'h2;
  localparam logic [3:0] first_ttl_source_enable = 4'h4;
  localparam logic [3:0] second_ttl_source_enable = 4'h8;
  localparam logic [3:0] GEN_MASK_RESET = 4'h1;
  localparam int BIT_SW = 0;
  localparam int BIT_ANALOG = 1;
  localparam int BIT_TTL0 = 2;
  localparam int BIT_TTL1 = 3;

  // ----------------------------------------------------------------
  // Connector modes.
  // ----------------------------------------------------------------
  localparam logic [31:0] connector_disabled_mode = 32'h0000_0000;
  localparam logic [31:0] connector_trigger_input_mode = 32'h0000_0001;
  localparam logic [31:0] connector_trigger_output_mode = 32'h0000_0020;
  localparam logic [31:0] connector_run_state_mode = 32'h0000_0100;

  // ----------------------------------------------------------------
  // Command, style and status bits, reset values of counters.
  // ----------------------------------------------------------------
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_WRITE_SETUP = 2;
  localparam int STYLE_DIRECT = 0;
  localparam int STYLE_FIFO = 1;
  localparam int STAT_RUN = 0;
  localparam int STAT_TRIG = 1;
  localparam int STAT_ARMED = 2;
  localparam logic [31:0] TRIG_DELAY_RESET = 32'h0000_0000;
  localparam logic [31:0] POST_COUNT_RESET = 32'h0000_0010;

  // Card sequence states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_POST = 4'b1000
  } card_state_e;

endpackage : trig_or_pkg

// file: bench/trigger_or_mask_props.sv
// Port checks for the trigger OR mask block.
module trigger_or_mask_props
  import trig_or_pkg::*;
#(
  parameter int NCH = 4,
  parameter logic [3:0] GEN_AVAIL = 4'hf,
  parameter logic [31:0] FIXED_DELAY = 32'h0000_0004
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [31:0] rdData,
  input wire logic analogCond,
  input wire logic [NCH-1:0] chanCond,
  input wire logic firstConnIn,
  input wire logic firstConnOut,
  input wire logic firstConnOeN,
  input wire logic secondConnIn,
  input wire logic secondConnOut,
  input wire logic secondConnOeN,
  input wire logic cardTrig,
  input wire logic running
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Command sequences
  // ----------------------------------------------------------------
  sequence startIdle;
    wrStb && addr == ADDR_COMMAND && wrData[CMD_START] && !wrData[CMD_STOP] && !running;
  endsequence
  sequence stopWr;
    wrStb && addr == ADDR_COMMAND && wrData[CMD_STOP];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_idle_a: assert property (!$past(rdStb) |-> rdData == 32'h0000_0000)
    else $error("read data not zero outside a read");
  avail_read_a: assert property (
    rdStb && addr == ADDR_AVAIL_GEN |=> rdData == {28'h000_0000, GEN_AVAIL})
    else $error("availability read wrong");
  mask_avail_a: assert property (
    rdStb && addr == ADDR_GEN_MASK |=> (rdData & ~{28'h000_0000, GEN_AVAIL}) == 0)
    else $error("unavailable mask bit stored");
  start_run_a: assert property (startIdle |=> running && !cardTrig)
    else $error("start did not arm the card");
  stop_idle_a: assert property (stopWr |=> !running && !cardTrig)
    else $error("stop did not end the run");
  trig_in_run_a: assert property ($rose(cardTrig) |-> $past(running))
    else $error("trigger without a run");
  run_end_a: assert property (
    $fell(running) |-> $past(cardTrig) ||
    $past(wrStb && addr == ADDR_COMMAND && wrData[CMD_STOP]))
    else $error("run ended without post area or stop");
  first_drive_a: assert property (
    !firstConnOeN |-> firstConnOut == running || firstConnOut == cardTrig)
    else $error("first connector drives a wrong level");
  second_drive_a: assert property (
    !secondConnOeN |-> secondConnOut == running || secondConnOut == cardTrig)
    else $error("second connector drives a wrong level");
  quiet_out_a: assert property (
    firstConnOeN && secondConnOeN |-> !firstConnOut && !secondConnOut)
    else $error("released connector output not low");
endmodule : trigger_or_mask_props

bind trigger_or_mask trigger_or_mask_props #(.NCH(NCH), .GEN_AVAIL(GEN_AVAIL),
  .FIXED_DELAY(FIXED_DELAY))
  i_props (.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
  .rdData(rdData), .analogCond(analogCond), .chanCond(chanCond), .firstConnIn(firstConnIn),
  .firstConnOut(firstConnOut), .firstConnOeN(firstConnOeN), .secondConnIn(secondConnIn),
  .secondConnOut(secondConnOut), .secondConnOeN(secondConnOeN), .cardTrig(cardTrig),
  .running(running));

// file: bench/ext_trig_equipment.sv
// External trigger equipment on the two multi-purpose connectors.
module ext_trig_equipment #(
  parameter int LAG = 2
) (
  input wire logic clk,
  input wire logic [1:0] fire,
  input wire logic [1:0] designOut,
  input wire logic [1:0] designOeN,
  output logic [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hist [4] = '{2'b00, 2'b00, 2'b00, 2'b00};
  // Trigger pulses leave the equipment LAG cycles late, so it is slow.
  always @(posedge clk) begin
    hist <= '{fire, hist[0], hist[1], hist[2]};
  end
  // Equipment drives a pin only while the card has released it.
  assign pin[0] = designOeN[0] ? hist[LAG-1][0] : designOut[0];
  assign pin[1] = designOeN[1] ? hist[LAG-1][1] : designOut[1];
endmodule : ext_trig_equipment

// file: bench/test_trigger_or_mask.sv
// Self-checking bench for the trigger OR mask block.
module test_trigger_or_mask
  import trig_or_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] FD = 32'h0000_0004;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wrData = 32'h0000_0000;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic analogCond = 1'b0;
  logic [3:0] chanCond = 4'h0;
  logic [1:0] fire = 2'b00;
  logic [1:0] pin;
  logic [31:0] rdData;
  logic fOut, fOeN, sOut, sOeN, cardTrig, running;
  logic [5:0] snap;
  logic [31:0] lfsr = 32'h0000_10b5;
  logic [31:0] d;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int rise, wid, k;
  always #50 clk = ~clk;
  trigger_or_mask #(.NCH(4), .GEN_AVAIL(4'hf), .FIXED_DELAY(FD)) i_dut (.clk(clk), .rstn(rstn),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .analogCond(analogCond), .chanCond(chanCond), .firstConnIn(pin[0]), .firstConnOut(fOut),
    .firstConnOeN(fOeN), .secondConnIn(pin[1]), .secondConnOut(sOut), .secondConnOeN(sOeN),
    .cardTrig(cardTrig), .running(running));
  ext_trig_equipment #(.LAG(2)) i_equip (.clk(clk), .fire(fire), .designOut({sOut, fOut}),
    .designOeN({sOeN, fOeN}), .pin(pin));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  // Strobes are lowered by idle, rd and the run loop, not by wr, so back-to-back writes never clash.
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrStb <= 1'b1;
  endtask : wr
  task automatic idle();
    @(posedge clk);
    wrStb <= 1'b0;
  endtask : idle
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    wrStb <= 1'b0;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    @(negedge clk);
    check(what, exp, rdData);
  endtask : rd
  // One run: program masks, style and delay, start, fire a source at cycle 3.
  task automatic trig_run(input logic [31:0] gm, cm, st, dly, input int src);
    wr(ADDR_GEN_MASK, gm);
    wr(ADDR_CH_MASK, cm);
    wr(ADDR_OUT_STYLE, st);
    wr(ADDR_TRIG_DELAY, dly);
    wr(ADDR_COMMAND, 32'h0000_0001);
    rise = -1;
    wid = 0;
    for (int i = 1; i < 60; i++) begin
      @(posedge clk);
      wrStb <= 1'b0;
      if (i == 3) begin
        analogCond <= (src == 1);
        fire <= {src == 3, src == 2};
        chanCond <= (src >= 4) ? 4'(1 << (src - 4)) : 4'h0;
      end
      @(negedge clk);
      if (i == 8) snap = {fOut, fOeN, sOut, sOeN, cardTrig, running};
      if (cardTrig === 1'b1 && rise < 0) rise = i;
      if (cardTrig === 1'b1) wid++;
    end
    @(posedge clk);
    analogCond <= 1'b0;
    fire <= 2'b00;
    chanCond <= 4'h0;
    wr(ADDR_COMMAND, 32'h0000_0002);
    idle();
  endtask : trig_run
  // Hang guard: the whole sequence needs far fewer cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_GEN_MASK, 32'h0000_0001, "gen mask reset");
    rd(ADDR_AVAIL_GEN, 32'h0000_000f, "gen avail");
    rd(ADDR_AVAIL_CH, 32'h0000_000f, "chan avail");
    rd(16'h0004, 32'h0000_0000, "unmapped");
    $display("reset values done");
    for (int n = 0; n < 10; n++) begin
      lfsr = next_rand(lfsr);
      d = (n < 5) ? (32'h0000_0001 << n) >> 1 : lfsr;
      wr(ADDR_GEN_MASK, d);
      rd(ADDR_GEN_MASK, d & 32'h0000_000f, "gen mask");
      wr(ADDR_CH_MASK, lfsr);
      rd(ADDR_CH_MASK, lfsr & 32'h0000_000f, "chan mask");
    end
    $display("mask registers done");
    for (int n = 0; n < 3; n++) begin
      lfsr = next_rand(lfsr);
      d = 32'(lfsr[2:0]);
      trig_run(32'h0000_0001, 0, 0, d, 0);
      check("std rise", FD + 32'h0000_0002 + d, 32'(rise));
      check("std width", 32'h0000_0010, 32'(wid));
      trig_run(32'h0000_0001, 0, 32'h0000_0001, d, 0);
      check("dir rise", 32'h0000_0002, 32'(rise));
      check("dir width", FD + d + 32'h0000_0010, 32'(wid));
      trig_run(32'h0000_0002, 0, 32'h0000_0001, d, 1);
      check("ext dir rise", 32'h0000_0004, 32'(rise));
      check("ext dir width", FD + d + 32'h0000_0010, 32'(wid));
    end
    trig_run(32'h0000_0002, 0, 0, 0, 1);
    check("analog", 32'h0000_0010, 32'(wid));
    trig_run(32'h0000_0000, 0, 0, 0, 1);
    check("masked analog", 32'hffff_ffff, 32'(rise));
    trig_run(32'h0000_0001, 0, 32'h0000_0002, 0, 0);
    check("fifo width", 32'h0000_003a - FD, 32'(wid));
    @(negedge clk);
    check("fifo stop", 32'h0000_0000, 32'({cardTrig, running}));
    rd(ADDR_STATUS, 32'h0000_0000, "status idle");
    $display("timing runs done");
    k = int'(lfsr[1:0]);
    trig_run(0, 32'h0000_0001 << k, 0, 0, 4 + k);
    check("chan trig", 32'h0000_0010, 32'(wid));
    trig_run(0, 32'h0000_0001 << k, 0, 0, 4 + ((k + 1) % 4));
    check("other chan", 32'hffff_ffff, 32'(rise));
    for (int j = 0; j < 2; j++) begin
      wr(j ? ADDR_MODE_SECOND : ADDR_MODE_FIRST, connector_trigger_input_mode);
      trig_run(32'h0000_0004 << j, 0, 0, 0, 2 + j);
      check("ttl trig", 32'h0000_0010, 32'(wid));
      wr(j ? ADDR_MODE_SECOND : ADDR_MODE_FIRST, connector_disabled_mode);
    end
    $display("source runs done");
    wr(ADDR_LEGACY_OUT, 32'h0000_0001);
    rd(ADDR_LEGACY_OUT, 32'h0000_0001, "legacy");
    trig_run(32'h0000_0001, 0, 0, 0, 0);
    check("legacy one", 32'h0000_002b, 32'(snap));
    wr(ADDR_MODE_SECOND, connector_disabled_mode);
    trig_run(32'h0000_0001, 0, 0, 0, 0);
    check("mode after legacy", 32'h0000_0027, 32'(snap));
    wr(ADDR_LEGACY_OUT, 32'h0000_0000);
    idle();
    @(negedge clk);
    check("not yet applied", 32'h0000_0000, 32'(fOeN));
    wr(ADDR_COMMAND, 32'h0000_0004);
    idle();
    @(negedge clk);
    check("legacy zero", 32'h0000_0003, 32'({fOeN, sOeN}));
    $display("connector runs done");
    wr(ADDR_POST_COUNT, 32'h0000_0003);
    rd(ADDR_POST_COUNT, 32'h0000_0003, "post count");
    trig_run(32'h0000_0001, 0, 0, 0, 0);
    check("post width", 32'h0000_0003, 32'(wid));
    $display("post count runs done");
    end_of_test();
  end
endmodule : test_trigger_or_mask
